// File: hdl/spsm_consts.vh
// Constants for the serial port special-modes block: offsets, fields, codes and counts.
// Behaviour
// - Sync master phase and order act like peripheral-interface
// - Sync pins: out, in, clock; no extras
// - Half-duplex 1 line driver, 2 transmitter drive control
// - Direction high one bit early, through stop
// - Standby start edge wakes oscillator and clock
// - False start bit turns the clock off
// - Start in standby detection sets start flag
// - Start detection off when active, idle, power-down
// - Shared receive interrupt, separate enables, wake choices
// - Oscillator stays on during ongoing communication
// - Break is more than eleven low bits
// - Bus mode sync must be 0x55, else error
// - Eight-bit-time count gives divider and fraction
// - Generic mode: no char check, update checked against a minimum only
// - Wait-for-break: next fall then rise is break
// - Single-wire: transmitter output feeds the receiver
// - Frame type: first stop bit or ninth bit
// - Filter mode drops data frames until address
// - Mode 2 is infrared, inverted pin, no double speed
// - Infrared transmit: 3/16, fixed clocks, or none
// - Infrared receive minimum width; event input option
`ifndef SPSM_CONSTS_VH
`define SPSM_CONSTS_VH
`define SPSM_ADDR_DATAL   4'h0
`define SPSM_ADDR_DATAH   4'h1
`define SPSM_ADDR_STATUS  4'h2
`define SPSM_ADDR_CTRLA   4'h3
`define SPSM_ADDR_CTRLB   4'h4
`define SPSM_ADDR_CTRLC   4'h5
`define SPSM_ADDR_BAUDL   4'h6
`define SPSM_ADDR_BAUDH   4'h7
`define SPSM_ADDR_EVCTRL  4'h8
`define SPSM_ADDR_TXPL    4'h9
`define SPSM_ADDR_RXPL    4'ha
`define SPSM_ST_RXC       7
`define SPSM_ST_DRE       5
`define SPSM_ST_RXS       4
`define SPSM_ST_ISF       3
`define SPSM_ST_BRK       1
`define SPSM_ST_WFB       0
`define SPSM_RST_CTRL     8'h00
`define SPSM_RST_BAUD     16'h0000
`define SPSM_RST_TXPL     8'h00
`define SPSM_RST_RXPL     7'h00
`define SPSM_HD_DRIVER    2'h1
`define SPSM_HD_TXCTL     2'h2
`define SPSM_RXM_GEN      2'h2
`define SPSM_RXM_BUS      2'h3
`define SPSM_CM_IR        2'h2
`define SPSM_CM_ASYNC     2'h0
`define SPSM_CM_SYNC      2'h3
`define SPSM_SLP_ACTIVE   2'h0
`define SPSM_SLP_STANDBY  2'h2
`define SPSM_CHSZ_9       3'h7
`define SPSM_SYNC_CHAR    8'h55
`define SPSM_BRK_TICKS    8'hb0
`define SPSM_BAUD_MIN     17'h00064
`define SPSM_BAUD_STEP    17'h00040
`define SPSM_IR_316       4'h3
`define SPSM_TXPL_NONE    8'hff
`define SPSM_SYNC_EDGES   3'h4
`endif

// File: hdl/spsm_core.v
// Serial port with sync master, half-duplex, start-frame, auto-baud, infrared and filter modes.
`include "spsm_consts.vh"
`default_nettype none
module spsm_core (
  input  wire       clk,
  input  wire       nrst,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output wire [7:0] rdata,
  input  wire       rxd_in,
  input  wire       ev_in,
  input  wire [1:0] sleep_mode,
  output wire       txd_out,
  output wire       txd_oe_n,
  output wire       transfer_clock_pin,
  output wire       transmit_direction_pin,
  output wire       rx_irq,
  output wire       wake_request,
  output wire       osc_request,
  output wire       clk_request
);
  localparam TX_IDLE  = 3'd0;
  localparam TX_LEAD  = 3'd1;
  localparam TX_START = 3'd2;
  localparam TX_DATA  = 3'd3;
  localparam TX_STOP  = 3'd4;
  localparam SY_RUN   = 3'd5;
  localparam RX_IDLE  = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA  = 2'd2;
  localparam RX_STOP  = 2'd3;
  localparam AB_IDLE  = 2'd0;
  localparam AB_WAIT  = 2'd1;
  localparam AB_MEAS  = 2'd2;
  localparam AB_CHK   = 2'd3;

  reg  [7:0]  ctrla_ff;
  reg  [7:0]  ctrlb_ff;
  reg  [7:0]  ctrlc_ff;
  reg  [15:0] baud_ff;
  reg         ev_sel_ff;
  reg  [7:0]  txpl_ff;
  reg  [6:0]  rxpl_ff;
  reg  [7:0]  rdata_ff;
  reg         rxc_ff;
  reg         rxs_ff;
  reg         isf_ff;
  reg         brk_ff;
  reg         wfb_ff;
  reg  [8:0]  rx_buf_ff;
  reg  [7:0]  tx_buf_ff;
  reg         tx_b8_ff;
  reg         tx_full_ff;
  reg  [15:0] acc_ff;
  reg  [2:0]  tx_state_ff;
  reg  [3:0]  tx_tick_ff;
  reg  [3:0]  tx_bit_ff;
  reg  [8:0]  tx_shift_ff;
  reg         tx_line_ff;
  reg         xck_ff;
  reg  [7:0]  sy_rx_ff;
  reg         sy_done_ff;
  reg  [7:0]  ir_clk_ff;
  reg         tx_pin_ff;
  reg  [6:0]  ir_low_ff;
  reg  [4:0]  ir_hold_ff;
  reg         rx_prev_ff;
  reg  [1:0]  rx_state_ff;
  reg  [3:0]  rx_tick_ff;
  reg  [3:0]  rx_bit_ff;
  reg  [1:0]  rx_vote_ff;
  reg  [8:0]  rx_shift_ff;
  reg         rx_done_ff;
  reg  [8:0]  rx_last_ff;
  reg  [7:0]  low_cnt_ff;
  reg         wfb_fell_ff;
  reg  [1:0]  ab_state_ff;
  reg  [16:0] meas_ff;
  reg  [2:0]  edge_cnt_ff;

  wire [1:0] half_duplex_select          = ctrla_ff[1:0];
  wire       loopback                    = ctrla_ff[3];
  wire       rxs_ie                      = ctrla_ff[4];
  wire       rxc_ie                      = ctrla_ff[7];
  wire       rx_en                       = ctrlb_ff[7];
  wire       tx_en                       = ctrlb_ff[6];
  wire       start_frame_detect_enable   = ctrlb_ff[4];
  wire [1:0] receive_mode_field          = ctrlb_ff[2:1];
  wire       multiprocessor_filter_mode  = ctrlb_ff[0];
  wire [1:0] communication_mode_field    = ctrlc_ff[7:6];
  wire       two_stop                    = ctrlc_ff[3];
  wire [2:0] chsize                      = ctrlc_ff[2:0];
  wire       sync_bit_order              = ctrlc_ff[2];
  wire       sync_clock_phase            = ctrlc_ff[1];
  wire       infrared_mode     = (communication_mode_field == `SPSM_CM_IR);
  wire       sync_mode         = (communication_mode_field == `SPSM_CM_SYNC);
  wire       bus_protocol_autobaud = (receive_mode_field == `SPSM_RXM_BUS);
  wire       generic_autobaud      = (receive_mode_field == `SPSM_RXM_GEN);
  wire       autobaud          = bus_protocol_autobaud | generic_autobaud;
  wire       nine_bit          = (chsize == `SPSM_CHSZ_9);
  wire [3:0] nbits = chsize[2] ? 4'd9 : ({1'b0, chsize} + 4'd5);
  wire       wr_status = wr & (addr == `SPSM_ADDR_STATUS);
  wire       wr_datal  = wr & (addr == `SPSM_ADDR_DATAL);
  wire       rd_datal  = rd & (addr == `SPSM_ADDR_DATAL);

  function [7:0] spsm_rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        spsm_rev8[i] = v[7 - i];
    end
  endfunction

  // Fractional divider: one sample tick per BAUD/64 clocks, sixteen ticks to a bit.
  wire [16:0] acc_sum = {1'b0, acc_ff} + `SPSM_BAUD_STEP;
  wire        tick    = (acc_sum >= {1'b0, baud_ff});
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      acc_ff <= 16'h0000;
    else if (tick)
      acc_ff <= acc_sum[15:0] - baud_ff;
    else
      acc_ff <= acc_sum[15:0];
  end

  // Transmit, half-duplex lead time and synchronous master.
  wire tx_busy  = (tx_state_ff != TX_IDLE);
  wire tx_take  = ~tx_busy & tx_full_ff & tx_en;
  wire sy_half  = tick & (tx_tick_ff[2:0] == 3'h7);
  wire tx_wrap  = tick & (tx_tick_ff == 4'hf);
  wire [7:0] sy_first = sync_bit_order ? tx_buf_ff : spsm_rev8(tx_buf_ff);
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_state_ff <= TX_IDLE;
      tx_tick_ff  <= 4'h0;
      tx_bit_ff   <= 4'h0;
      tx_shift_ff <= 9'h000;
      tx_line_ff  <= 1'b1;
      xck_ff      <= 1'b0;
      sy_rx_ff    <= 8'h00;
      sy_done_ff  <= 1'b0;
    end
    else
    begin
      sy_done_ff <= 1'b0;
      if (tick)
        tx_tick_ff <= tx_tick_ff + 4'h1;
      case (tx_state_ff)
        TX_IDLE:
        begin
          xck_ff <= 1'b0;
          if (tx_take)
          begin
            tx_tick_ff <= 4'h0;
            tx_bit_ff  <= 4'h0;
            if (sync_mode)
            begin
              tx_shift_ff <= {1'b0, sy_first};
              tx_line_ff  <= sy_first[0];
              tx_state_ff <= SY_RUN;
            end
            else
            begin
              tx_shift_ff <= {tx_b8_ff, tx_buf_ff};
              tx_line_ff  <= (half_duplex_select != 2'h0);
              tx_state_ff <= (half_duplex_select != 2'h0) ? TX_LEAD : TX_START;
            end
          end
        end
        TX_LEAD:
          if (tx_wrap)
          begin
            tx_line_ff  <= 1'b0;
            tx_state_ff <= TX_START;
          end
        TX_START, TX_DATA:
          if (tx_wrap)
          begin
            if (tx_bit_ff == nbits)
            begin
              tx_line_ff  <= 1'b1;
              tx_bit_ff   <= 4'h1;
              tx_state_ff <= TX_STOP;
            end
            else
            begin
              tx_line_ff  <= tx_shift_ff[0];
              tx_shift_ff <= {1'b0, tx_shift_ff[8:1]};
              tx_bit_ff   <= tx_bit_ff + 4'h1;
              tx_state_ff <= TX_DATA;
            end
          end
        TX_STOP:
          if (tx_wrap)
          begin
            if (tx_bit_ff == (two_stop ? 4'h2 : 4'h1))
              tx_state_ff <= TX_IDLE;
            else
              tx_bit_ff <= tx_bit_ff + 4'h1;
          end
        SY_RUN:
          if (sy_half)
          begin
            // Leading edge at the end of even halves, trailing at the end of odd ones.
            xck_ff <= ~tx_bit_ff[0] & (tx_bit_ff != 4'hf);
            if (tx_bit_ff[0] == sync_clock_phase)
              sy_rx_ff <= {rxd_in, sy_rx_ff[7:1]};
            else if (tx_bit_ff != 4'h0)
            begin
              tx_line_ff  <= tx_shift_ff[1];
              tx_shift_ff <= {1'b0, tx_shift_ff[8:1]};
            end
            tx_bit_ff <= tx_bit_ff + 4'h1;
            if (tx_bit_ff == 4'hf)
            begin
              tx_state_ff <= TX_IDLE;
              tx_line_ff  <= 1'b1;
              sy_done_ff  <= 1'b1;
            end
          end
        default:
          tx_state_ff <= TX_IDLE;
      endcase
    end
  end

  // Infrared pulse shaping; a pulse drives the pin low.
  wire ir_pulse = (txpl_ff == `SPSM_RST_TXPL) ? (~tx_line_ff & (tx_tick_ff < `SPSM_IR_316)) :
                  (txpl_ff == `SPSM_TXPL_NONE) ? ~tx_line_ff :
                  (~tx_line_ff & (ir_clk_ff < txpl_ff));
  wire nxt_tx_pin = (infrared_mode & tx_busy) ? ~ir_pulse : tx_line_ff;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ir_clk_ff <= 8'h00;
      tx_pin_ff <= 1'b1;
    end
    else
    begin
      tx_pin_ff <= nxt_tx_pin;
      if (tx_wrap | tx_take)
        ir_clk_ff <= 8'h00;
      else if (ir_clk_ff != 8'hff)
        ir_clk_ff <= ir_clk_ff + 8'h01;
    end
  end

  assign txd_out                = tx_pin_ff;
  assign txd_oe_n               = (half_duplex_select == `SPSM_HD_TXCTL) ? ~tx_busy : 1'b0;
  assign transmit_direction_pin = (half_duplex_select != 2'h0) & tx_busy & ~sync_mode;
  assign transfer_clock_pin     = xck_ff;

  // Receive source: loopback, event input or pin, then infrared decode.
  wire rx_src  = loopback ? tx_pin_ff : (ev_sel_ff ? ev_in : rxd_in);
  wire [6:0] rxpl_min = (rxpl_ff == 7'h00) ? 7'h01 : rxpl_ff;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ir_low_ff  <= 7'h00;
      ir_hold_ff <= 5'h00;
    end
    else
    begin
      if (rx_src)
        ir_low_ff <= 7'h00;
      else if (ir_low_ff != 7'h7f)
        ir_low_ff <= ir_low_ff + 7'h01;
      // A qualified pulse is held as a zero for one bit time; short ones never qualify.
      if (~rx_src & (ir_low_ff == rxpl_min - 7'h01))
        ir_hold_ff <= 5'h10;
      else if (tick & (ir_hold_ff != 5'h00))
        ir_hold_ff <= ir_hold_ff - 5'h01;
    end
  end
  wire rx_line = infrared_mode ? (ir_hold_ff == 5'h00) : rx_src;
  wire rx_fall = rx_prev_ff & ~rx_line;
  wire rx_rise = ~rx_prev_ff & rx_line;

  // Asynchronous receiver with three-sample majority at the bit centre.
  wire       rx_busy = (rx_state_ff != RX_IDLE);
  wire [1:0] ones    = rx_vote_ff + {1'b0, rx_line};
  wire       maj     = ones[1];
  wire       centre  = tick & (rx_tick_ff == 4'h9);
  wire [8:0] rx_full = {maj, rx_shift_ff[8:1]};
  wire [8:0] rx_data = rx_shift_ff >> (4'd9 - nbits);
  wire       ftype   = nine_bit ? rx_data[8] : maj;
  wire       is_break = autobaud & ~maj & (rx_data == 9'h000);
  wire       rx_accept = (rx_state_ff == RX_STOP) & centre & rx_en & ~is_break &
                         ~(multiprocessor_filter_mode & ~ftype);
  wire       sfd_active = start_frame_detect_enable & (sleep_mode == `SPSM_SLP_STANDBY) &
                          (communication_mode_field == `SPSM_CM_ASYNC) & rx_en;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_prev_ff  <= 1'b1;
      rx_state_ff <= RX_IDLE;
      rx_tick_ff  <= 4'h0;
      rx_bit_ff   <= 4'h0;
      rx_vote_ff  <= 2'h0;
      rx_shift_ff <= 9'h000;
      rx_done_ff  <= 1'b0;
      rx_last_ff  <= 9'h000;
    end
    else
    begin
      rx_prev_ff <= rx_line;
      rx_done_ff <= 1'b0;
      if (tick & rx_busy)
      begin
        rx_tick_ff <= rx_tick_ff + 4'h1;
        if (rx_tick_ff == 4'h7)
          rx_vote_ff <= {1'b0, rx_line};
        else if (rx_tick_ff == 4'h8)
          rx_vote_ff <= ones;
      end
      case (rx_state_ff)
        RX_IDLE:
          if (rx_fall & rx_en & ~sync_mode)
          begin
            rx_tick_ff  <= 4'h0;
            rx_bit_ff   <= 4'h0;
            rx_state_ff <= RX_START;
          end
        RX_START:
          if (centre & maj)
            rx_state_ff <= RX_IDLE;
          else if (tick & (rx_tick_ff == 4'hf))
            rx_state_ff <= RX_DATA;
        RX_DATA:
        begin
          if (centre)
          begin
            rx_shift_ff <= rx_full;
            rx_bit_ff   <= rx_bit_ff + 4'h1;
          end
          if (tick & (rx_tick_ff == 4'hf) & (rx_bit_ff == nbits))
            rx_state_ff <= RX_STOP;
        end
        RX_STOP:
          if (centre)
          begin
            // Ending at the stop centre lets the next start bit come early.
            rx_done_ff  <= 1'b1;
            rx_last_ff  <= rx_data;
            rx_state_ff <= RX_IDLE;
          end
        default:
          rx_state_ff <= RX_IDLE;
      endcase
    end
  end
  wire start_seen = (rx_state_ff == RX_START) & centre & ~maj & sfd_active;

  // Break detection and baud measurement.
  wire brk_low  = autobaud & ~rx_line & (low_cnt_ff == `SPSM_BRK_TICKS) & tick;
  wire brk_wfb  = wfb_ff & wfb_fell_ff & rx_rise;
  wire brk_hit  = brk_low | brk_wfb;
  wire [16:0] new_baud  = {1'b0, meas_ff[16:1]};
  wire        sync_ok   = bus_protocol_autobaud ? (rx_last_ff[7:0] == `SPSM_SYNC_CHAR) :
                          (new_baud >= `SPSM_BAUD_MIN);
  // A sync frame that ends before its fifth falling edge is judged too, so a bad char flags.
  wire        ab_done   = ((ab_state_ff == AB_CHK) | (ab_state_ff == AB_MEAS)) & rx_done_ff;
  wire        ab_update = ab_done & sync_ok & (ab_state_ff == AB_CHK);
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_cnt_ff  <= 8'h00;
      wfb_fell_ff <= 1'b0;
      ab_state_ff <= AB_IDLE;
      meas_ff     <= 17'h00000;
      edge_cnt_ff <= 3'h0;
    end
    else
    begin
      if (rx_line)
        low_cnt_ff <= 8'h00;
      else if (tick & (low_cnt_ff != 8'hff))
        low_cnt_ff <= low_cnt_ff + 8'h01;
      if (~wfb_ff | brk_wfb)
        wfb_fell_ff <= 1'b0;
      else if (rx_fall)
        wfb_fell_ff <= 1'b1;
      case (ab_state_ff)
        AB_IDLE:
          if (brk_hit)
            ab_state_ff <= AB_WAIT;
        AB_WAIT:
          if (rx_fall)
          begin
            meas_ff     <= 17'h00000;
            edge_cnt_ff <= 3'h0;
            ab_state_ff <= AB_MEAS;
          end
        AB_MEAS:
        begin
          // Counted in clocks; half of eight bit times in clocks is the new BAUD.
          if (meas_ff != 17'h1ffff)
            meas_ff <= meas_ff + 17'h00001;
          if (rx_fall)
          begin
            edge_cnt_ff <= edge_cnt_ff + 3'h1;
            if (edge_cnt_ff == `SPSM_SYNC_EDGES - 3'h1)
              ab_state_ff <= AB_CHK;
          end
          if (rx_done_ff)
            ab_state_ff <= AB_IDLE;
        end
        AB_CHK:
          if (rx_done_ff)
            ab_state_ff <= AB_IDLE;
        default:
          ab_state_ff <= AB_IDLE;
      endcase
      if (~autobaud & ~wfb_ff)
        ab_state_ff <= AB_IDLE;
    end
  end

  // Register file; hardware events win over a clear in the same cycle.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrla_ff   <= `SPSM_RST_CTRL;
      ctrlb_ff   <= `SPSM_RST_CTRL;
      ctrlc_ff   <= `SPSM_RST_CTRL;
      baud_ff    <= `SPSM_RST_BAUD;
      ev_sel_ff  <= 1'b0;
      txpl_ff    <= `SPSM_RST_TXPL;
      rxpl_ff    <= `SPSM_RST_RXPL;
      rdata_ff   <= 8'h00;
      rxc_ff     <= 1'b0;
      rxs_ff     <= 1'b0;
      isf_ff     <= 1'b0;
      brk_ff     <= 1'b0;
      wfb_ff     <= 1'b0;
      rx_buf_ff  <= 9'h000;
      tx_buf_ff  <= 8'h00;
      tx_b8_ff   <= 1'b0;
      tx_full_ff <= 1'b0;
    end
    else
    begin
      if (wr)
        case (addr)
          `SPSM_ADDR_DATAL:  tx_buf_ff <= wdata;
          `SPSM_ADDR_DATAH:  tx_b8_ff  <= wdata[0];
          `SPSM_ADDR_CTRLA:  ctrla_ff  <= wdata;
          `SPSM_ADDR_CTRLB:  ctrlb_ff  <= wdata;
          `SPSM_ADDR_CTRLC:  ctrlc_ff  <= wdata;
          `SPSM_ADDR_BAUDL:  baud_ff   <= {baud_ff[15:8], wdata};
          `SPSM_ADDR_BAUDH:  baud_ff   <= {wdata, baud_ff[7:0]};
          `SPSM_ADDR_EVCTRL: ev_sel_ff <= wdata[0];
          `SPSM_ADDR_TXPL:   txpl_ff   <= wdata;
          `SPSM_ADDR_RXPL:   rxpl_ff   <= wdata[6:0];
          default:           ;
        endcase
      if (ab_update)
        baud_ff <= new_baud[15:0];
      tx_full_ff <= wr_datal | (tx_full_ff & ~tx_take);
      if (rx_accept)
        rx_buf_ff <= rx_data;
      else if (sy_done_ff)
        rx_buf_ff <= {1'b0, sync_bit_order ? sy_rx_ff : spsm_rev8(sy_rx_ff)};
      rxc_ff <= rx_accept | sy_done_ff | (rxc_ff & ~rd_datal);
      rxs_ff <= start_seen | (rxs_ff & ~(wr_status & wdata[`SPSM_ST_RXS]));
      isf_ff <= (ab_done & ~ab_update) | (isf_ff & ~(wr_status & wdata[`SPSM_ST_ISF]));
      brk_ff <= brk_hit | (brk_ff & ~(wr_status & wdata[`SPSM_ST_BRK]));
      wfb_ff <= (wr_status & wdata[`SPSM_ST_WFB]) | (wfb_ff & ~brk_wfb);
      if (rd)
        case (addr)
          `SPSM_ADDR_DATAL:  rdata_ff <= rx_buf_ff[7:0];
          `SPSM_ADDR_DATAH:  rdata_ff <= {rxc_ff, 6'h00, rx_buf_ff[8]};
          `SPSM_ADDR_STATUS: rdata_ff <= {rxc_ff, 1'b0, ~tx_full_ff, rxs_ff, isf_ff,
                                          1'b0, brk_ff, wfb_ff};
          `SPSM_ADDR_CTRLA:  rdata_ff <= ctrla_ff;
          `SPSM_ADDR_CTRLB:  rdata_ff <= ctrlb_ff;
          `SPSM_ADDR_CTRLC:  rdata_ff <= ctrlc_ff;
          `SPSM_ADDR_BAUDL:  rdata_ff <= baud_ff[7:0];
          `SPSM_ADDR_BAUDH:  rdata_ff <= baud_ff[15:8];
          `SPSM_ADDR_EVCTRL: rdata_ff <= {7'h00, ev_sel_ff};
          `SPSM_ADDR_TXPL:   rdata_ff <= txpl_ff;
          `SPSM_ADDR_RXPL:   rdata_ff <= {1'b0, rxpl_ff};
          default:           rdata_ff <= 8'h00;
        endcase
      else
        rdata_ff <= 8'h00;
    end
  end
  assign rdata = rdata_ff;

  // Power requests: the oscillator holds while any frame is in flight.
  wire comm_busy = rx_busy | tx_busy;
  wire irq_src   = (rxc_ff & rxc_ie) | (rxs_ff & rxs_ie);
  assign rx_irq       = irq_src;
  assign wake_request = (sleep_mode != `SPSM_SLP_ACTIVE) & irq_src;
  assign osc_request  = comm_busy | (sfd_active & ~rx_line);
  assign clk_request  = (sleep_mode != `SPSM_SLP_STANDBY) | comm_busy |
                        (sfd_active & ~rx_line);
endmodule // spsm_core
`default_nettype wire

// File: bench/spsm_core_monitor.sv
// Port-level assertions for the serial port special-modes core.
`default_nettype none
module spsm_monitor (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rxd_in,
  input wire logic       ev_in,
  input wire logic [1:0] sleep_mode,
  input wire logic       txd_out,
  input wire logic       txd_oe_n,
  input wire logic       transfer_clock_pin,
  input wire logic       transmit_direction_pin,
  input wire logic       rx_irq,
  input wire logic       wake_request,
  input wire logic       osc_request,
  input wire logic       clk_request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // The lead bit keeps the idle level on the line while the driver turns on.
  a_dir_lead: assert property ($rose(transmit_direction_pin) |-> txd_out [*8])
    else $error("direction rose without a lead bit");
  a_dir_frame_end: assert property (
    $fell(transmit_direction_pin) |-> txd_out && $past(txd_out, 8))
    else $error("direction dropped before the stop bit ended");
  a_oe_drive: assert property ($fell(txd_out) |-> !txd_oe_n)
    else $error("low bit sent while the pin is not driven");
  a_sck_half: assert property ($rose(transfer_clock_pin) |-> transfer_clock_pin [*4])
    else $error("transfer clock high phase too short");
  a_wake_mirror: assert property (wake_request == (rx_irq && sleep_mode != 2'h0))
    else $error("wake request does not follow the receive interrupt");
  a_clk_active: assert property (sleep_mode != 2'h2 |-> clk_request)
    else $error("clock dropped outside standby");
  a_clk_standby: assert property (
    sleep_mode == 2'h2 |-> clk_request == osc_request)
    else $error("standby clock request differs from oscillator request");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside the read answer cycle");
endmodule // spsm_monitor
bind spsm_core spsm_monitor spsm_monitor_i (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
  .rxd_in, .ev_in, .sleep_mode, .txd_out, .txd_oe_n, .transfer_clock_pin,
  .transmit_direction_pin, .rx_irq, .wake_request, .osc_request, .clk_request);
`default_nettype wire

// File: bench/spsm_node.sv
// Remote serial node model driving the receive line of the core.
`default_nettype none
module spsm_node (
  input  wire logic clk,
  output var  logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line = 1'b1;
  // Each level lasts n clocks, so slow and fast senders are both possible.
  task automatic hold(input logic v, input int n);
    @(posedge clk);
    line <= v;
    repeat (n - 1) @(posedge clk);
  endtask
  // Two stop bits, because the first one carries the frame type.
  task automatic send(input logic [7:0] ch, input logic st1, input int bt);
    int i;
    hold(1'b0, bt);
    for (i = 0; i < 8; i++) hold(ch[i], bt);
    hold(st1, bt);
    hold(1'b1, bt);
  endtask
endmodule // spsm_node
`default_nettype wire

// File: bench/tb_spsm_core.sv
// Self-checking bench for the serial port special-modes core.
`default_nettype none
module tb_spsm_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       ev_in = 1'b0;
  logic [1:0] sleep_mode = 2'h0;
  wire logic  rxd_in;
  wire [7:0]  rdata;
  wire        txd_out, txd_oe_n, transfer_clock_pin, transmit_direction_pin;
  wire        rx_irq, wake_request, osc_request, clk_request;
  int         fail_count = 0;
  int         checked = 0;
  spsm_core spsm_core_i (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .rxd_in, .ev_in,
    .sleep_mode, .txd_out, .txd_oe_n, .transfer_clock_pin, .transmit_direction_pin,
    .rx_irq, .wake_request, .osc_request, .clk_request);
  spsm_node spsm_node_i (.clk(clk), .line(rxd_in));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check({8'h00, rdata & m}, {8'h00, e});
  endtask
  task automatic wait_low();
    int n;
    n = 0;
    while (txd_out !== 1'b0 && n < 600)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic t_tx();
    logic [9:0] f = {1'b1, 8'ha5, 1'b0};
    int i;
    wreg(4'h6, 8'h40);
    wreg(4'h5, 8'h03);
    wreg(4'h3, 8'h0a);
    wreg(4'h4, 8'hc0);
    #1 check(16'(txd_oe_n), 16'h1);
    wreg(4'h0, 8'ha5);
    wait_low();
    repeat (8) @(posedge clk);
    for (i = 0; i < 10; i++)
    begin
      #1 check(16'({txd_out, transmit_direction_pin, txd_oe_n}), 16'({f[i], 2'b10}));
      repeat (16) @(posedge clk);
    end
    rchk(4'h0, 8'hff, 8'ha5);
  endtask
  task automatic t_multiprocessor_filter_mode();
    wreg(4'h3, 8'h00);
    wreg(4'h4, 8'h81);
    spsm_node_i.send(8'h3c, 1'b0, 16);
    rchk(4'h2, 8'h80, 8'h00);
    spsm_node_i.send(8'ha7, 1'b1, 16);
    rchk(4'h0, 8'hff, 8'ha7);
  endtask
  task automatic t_ir();
    logic [7:0] pl [3] = '{8'h00, 8'h07, 8'hff};
    int w [3] = '{3, 7, 16};
    int i;
    int n;
    wreg(4'h4, 8'h40);
    wreg(4'h5, 8'h83);
    for (i = 0; i < 3; i++)
    begin
      wreg(4'h9, pl[i]);
      wreg(4'h0, 8'hff);
      wait_low();
      n = 0;
      while (txd_out === 1'b0 && n < 40)
      begin
        @(posedge clk);
        #1 n++;
      end
      check(16'(n), 16'(w[i]));
      repeat (200) @(posedge clk);
    end
  endtask
  task automatic t_sync();
    logic [7:0] v;
    logic [7:0] n;
    logic p;
    int i;
    int t;
    for (i = 0; i < 2; i++)
    begin
      wreg(4'h5, i ? 8'hc0 : 8'hc4);
      wreg(4'h0, 8'h01);
      v = 8'h00;
      n = 8'h00;
      p = 1'b0;
      for (t = 0; t < 300; t++)
      begin
        @(posedge clk);
        #1 if (transfer_clock_pin === 1'b1 && !p)
        begin
          v = {v[6:0], txd_out};
          n++;
        end
        p = transfer_clock_pin;
      end
      check({n, v}, {8'h08, i ? 8'h01 : 8'h80});
    end
  endtask
  task automatic t_sleep();
    wreg(4'h5, 8'h03);
    wreg(4'h3, 8'h10);
    wreg(4'h4, 8'h90);
    sleep_mode <= 2'h2;
    repeat (4) @(posedge clk);
    #1 check(16'({clk_request, wake_request}), 16'h0);
    fork
      spsm_node_i.send(8'h5a, 1'b1, 16);
      begin
        repeat (4) @(posedge clk);
        #1 check(16'({osc_request, clk_request}), 16'h3);
      end
    join
    #1 check(16'({rx_irq, wake_request}), 16'h3);
    rchk(4'h2, 8'h10, 8'h10);
    @(posedge clk);
    sleep_mode <= 2'h0;
    wreg(4'h2, 8'h10);
    rchk(4'h0, 8'h00, 8'h00);
    spsm_node_i.send(8'h5a, 1'b1, 16);
    rchk(4'h2, 8'h10, 8'h00);
    rchk(4'h0, 8'hff, 8'h5a);
  endtask
  task automatic t_ab();
    logic [7:0] md [4] = '{8'h86, 8'h86, 8'h84, 8'h84};
    logic [7:0] ch [4] = '{8'h55, 8'h15, 8'h55, 8'h55};
    int bt [4] = '{33, 33, 24, 30};
    logic [7:0] eb [4] = '{8'h84, 8'h84, 8'h84, 8'h78};
    int i;
    wreg(4'h3, 8'h00);
    wreg(4'h6, 8'h80);
    for (i = 0; i < 4; i++)
    begin
      wreg(4'h4, md[i]);
      if (i == 3) wreg(4'h2, 8'h01);
      spsm_node_i.hold(1'b0, i == 3 ? 5 : 470);
      spsm_node_i.hold(1'b1, 40);
      spsm_node_i.send(ch[i], 1'b1, bt[i]);
      // A fast sender ends well before the slower receiver reaches its stop centre.
      repeat (160) @(posedge clk);
      rchk(4'h6, 8'hff, eb[i]);
      rchk(4'h2, 8'h09, {4'h0, i == 1 || i == 2, 3'h0});
      wreg(4'h2, 8'h1a);
      rchk(4'h0, 8'h00, 8'h00);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    logic [3:0] a [8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hf};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    foreach (a[i]) rchk(a[i], 8'hff, 8'h00);
    t_tx();
    t_multiprocessor_filter_mode();
    t_ir();
    t_sync();
    t_sleep();
    t_ab();
    complete_run();
  end
  initial
  begin
    #3ms;
    fail_count++;
    complete_run();
  end
endmodule // tb_spsm_core
`default_nettype wire
